// ==== bench/baseline_core_tb.sv ====
// Self-checking bench for the baseline core: program and file memories, register port.
// Assumes the core package and the design files are compiled first.
`timescale 1ns/100ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module baseline_core_tb;
  import core_pkg::*;
  logic clk, rst_n, ce, reg_wr, reg_rd, file_we, pres_guard, timeout_evt, sleep_evt;
  logic guard_timer_clr, prescaler_clr, timeout_flag, sleep_flag;
  logic [RADDR_W-1:0] reg_addr;
  logic [REG_W-1:0] reg_wdata, reg_rdata;
  logic [PCTR_W-1:0] prog_addr, stack_head, last_addr;
  logic [WORD_W-1:0] prog_word;
  logic [FADDR_W-1:0] file_addr;
  logic [DATA_W-1:0] file_rdata, file_wdata, accum;
  logic [PAGE_W-1:0] status_page;
  logic [WORD_W-1:0] pmem [0:2047];
  logic [DATA_W-1:0] fmem [0:31];
  int failures, compares, cycles, since, kicks, pre_clrs;
  logic running, seen;
  logic [7:0] lit, f4, m_acc, m_f6, m_f7, msk;
  logic [2:0] bn;
  logic [12:0] exp_q [$];
  logic [12:0] exp_w;

  assign prog_word = pmem[prog_addr];
  assign file_rdata = fmem[file_addr];

  baseline_core baseline_core_inst (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .prog_addr(prog_addr), .prog_word(prog_word), .file_addr(file_addr), .file_rdata(file_rdata),
    .file_wdata(file_wdata), .file_we(file_we), .status_page(status_page), .pres_guard(pres_guard),
    .timeout_evt(timeout_evt), .sleep_evt(sleep_evt), .guard_timer_clr(guard_timer_clr),
    .prescaler_clr(prescaler_clr), .timeout_flag(timeout_flag), .sleep_flag(sleep_flag),
    .stack_head(stack_head), .accum(accum));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude();
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // File writes land one cycle after Q4, address still held
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 5000)
    begin
      failures++;
      conclude();
    end
    if (file_we === 1'b1)
    begin
      fmem[file_addr] <= file_wdata;
      // An unexpected write is forced to mismatch
      if (exp_q.size() > 0)
        exp_w = exp_q.pop_front();
      else
        exp_w = ~{file_addr, file_wdata};
      `CHK({file_addr, file_wdata}, exp_w)
    end
    if (guard_timer_clr === 1'b1)
      kicks++;
    if (prescaler_clr === 1'b1)
      pre_clrs++;
  end

  // Fetch address moves once per instruction cycle, flushed cycles included
  always @(posedge clk)
  begin
    if (running)
    begin
      since++;
      if (prog_addr !== last_addr)
      begin
        if (seen)
          `CHK(since, OSC_PER_CYCLE)
        seen <= 1'b1;
        since = 0;
      end
    end
    last_addr = prog_addr;
  end

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  logic [15:0] rd;
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    pres_guard = 1'b1;
    timeout_evt = 1'b0;
    sleep_evt = 1'b0;
    status_page = 2'h1;
    failures = 0;
    compares = 0;
    cycles = 0;
    since = 0;
    kicks = 0;
    pre_clrs = 0;
    running = 1'b0;
    seen = 1'b0;
    void'($urandom(32'h578a93cf));
    lit = 8'($urandom);
    f4 = 8'($urandom);
    for (int i = 0; i < 2048; i++)
      pmem[i] = NOP_WORD;
    for (int i = 0; i < 32; i++)
      fmem[i] = 8'($urandom);
    fmem[4] = f4;
    bn = 3'($urandom);
    msk = 8'h01 << bn;
    // Model of the program below: accumulator and every expected file write
    m_acc = (lit | 8'h35) | fmem[5];
    m_f6 = fmem[6] - m_acc;
    m_f7 = fmem[7] | msk;
    exp_q.push_back({5'h04, f4[3:0], f4[7:4]});
    exp_q.push_back({5'h06, m_f6});
    exp_q.push_back({5'h07, m_f7});
    m_f7 = m_f7 & ~(8'h01 << (bn ^ 3'h1));
    exp_q.push_back({5'h07, m_f7});
    exp_q.push_back({5'h08, 8'h00});
    // Words behind the call and the taken skip are poisoned; a missed flush after the call shows in the accumulator
    pmem[0] = {OP_MOVL, lit};
    pmem[1] = {OP_IORL, 8'h35};
    pmem[2] = OP_KICK;
    pmem[3] = {OP_CALL, 8'h20};
    pmem[4] = {OP_MOVL, 8'hff};
    pmem[11'h220] = {OP_SWAP, 1'b1, 5'h04};
    pmem[11'h221] = {OP_IOR_F, 1'b0, 5'h05};
    pmem[11'h222] = {OP_SUB, 1'b1, 5'h06};
    pmem[11'h223] = {OP_BSET, bn, 5'h07};
    pmem[11'h224] = {OP_BCLR, bn ^ 3'h1, 5'h07};
    pmem[11'h225] = {OP_SKIPS, bn, 5'h07};
    pmem[11'h226] = {OP_MOVL, 8'hff};
    pmem[11'h227] = {OP_SKIPC, bn, 5'h07};
    pmem[11'h228] = {OP_CLR, 1'b1, 5'h08};
    pmem[11'h229] = {OP_CLR, 1'b0, 5'h00};
    pmem[11'h22a] = {OP_IOR_F, 1'b0, 5'h06};
    pmem[11'h22b] = {OP_JUMP, 9'h100};
    pmem[11'h300] = {OP_JUMP, 9'h100};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK({timeout_flag, sleep_flag}, 2'b11)
    `CHK(prog_addr, PCTR_RST)
    reg_read(REG_CTRL, rd);
    `CHK(rd, 16'h0000)
    reg_read(4'h7, rd);
    `CHK(rd, 16'h0000)
    @(posedge clk);
    timeout_evt <= 1'b1;
    sleep_evt <= 1'b1;
    @(posedge clk);
    timeout_evt <= 1'b0;
    sleep_evt <= 1'b0;
    reg_read(REG_FLAGS, rd);
    `CHK(rd, 16'h0000)
    @(posedge clk);
    ce <= 1'b0;
    reg_write(REG_CTRL, 16'h0001);
    ce <= 1'b1;
    reg_read(REG_CTRL, rd);
    `CHK(rd, 16'h0000)
    reg_write(REG_PCTR, 16'h0155);
    reg_read(REG_PCTR, rd);
    `CHK(rd, 16'h0000)
    reg_write(REG_CTRL, 16'h0001);
    running = 1'b1;
    repeat (200) @(posedge clk);
    reg_write(REG_CTRL, 16'h0000);
    repeat (8) @(posedge clk);
    running = 1'b0;
    #1;
    `CHK(prog_addr[10:1], 10'h180)
    `CHK(accum, m_f6)
    `CHK(exp_q.size(), 0)
    `CHK(fmem[4], {f4[3:0], f4[7:4]})
    `CHK(stack_head, 11'h004)
    `CHK({timeout_flag, sleep_flag}, 2'b11)
    `CHK(kicks, 1)
    `CHK(pre_clrs, 1)
    reg_read(REG_ACC, rd);
    `CHK(rd, {8'h00, m_f6})
    reg_read(REG_STACK, rd);
    `CHK(rd, 16'h0004)
    reg_read(REG_FLAGS, rd);
    `CHK(rd, 16'h0003)
    conclude();
  end
endmodule

// ==== hdl/baseline_core.sv ====
// Fetch, decode and execute sequencer of the baseline 12-bit-word core.
// Assumes program memory, file registers and status page on the same clock.
// Function
// - Fetch and decode each instruction as one 12-bit word of opcode and operands.
// - Byte operations address one of 32 file registers in the current bank.
// - Destination bit 0 sends result to accumulator, 1 back to file register.
// - Byte format: opcode 11..6, destination bit 5, file address 4..0.
// - Bit format: opcode 11..8, bit number 7..5, file address 4..0.
// - Literal format: opcode 11..8, 8-bit immediate 7..0.
// - Long jump format: opcode 11..9, 9-bit target 8..0.
// - One cycle per instruction; two when a skip is taken or the counter changes.
// - An instruction cycle lasts four oscillator periods.
// - Call pushes the next address onto the stack and takes two cycles.
// - Call loads immediate into counter 7..0, page bits into 10..9, clears 8.
// - Guard timer kick clears timer, prescaler if assigned, sets both flags.
// - Don't-care bits never change decoding.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module baseline_core
  import core_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [RADDR_W-1:0] reg_addr,
  input wire logic [REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [REG_W-1:0] reg_rdata,
  output logic [PCTR_W-1:0] prog_addr,
  input wire logic [WORD_W-1:0] prog_word,
  output logic [FADDR_W-1:0] file_addr,
  input wire logic [DATA_W-1:0] file_rdata,
  output logic [DATA_W-1:0] file_wdata,
  output logic file_we,
  input wire logic [PAGE_W-1:0] status_page,
  input wire logic pres_guard,
  input wire logic timeout_evt,
  input wire logic sleep_evt,
  output logic guard_timer_clr,
  output logic prescaler_clr,
  output logic timeout_flag,
  output logic sleep_flag,
  output logic [PCTR_W-1:0] stack_head,
  output logic [DATA_W-1:0] accum
);

  typedef struct packed {
    logic [WORD_W-1:0] instr;
    logic [PCTR_W-1:0] pctr;
    logic [DATA_W-1:0] acc;
    logic [PCTR_W-1:0] stack;
    logic [DATA_W-1:0] operand;
    logic flush;
    logic [FADDR_W-1:0] faddr;
    logic [DATA_W-1:0] fwdata;
    logic fwe;
    logic kick;
    logic pres_clr;
    logic tmo;
    logic slp;
    logic run;
    logic [REG_W-1:0] rdata;
  } core_state_t;

  localparam core_state_t ST_RST = '{
    instr: NOP_WORD, pctr: PCTR_RST, acc: '0, stack: PCTR_RST, operand: '0,
    flush: 1'b0, faddr: '0, fwdata: '0, fwe: 1'b0, kick: 1'b0,
    pres_clr: 1'b0, tmo: FLAG_RST, slp: FLAG_RST, run: RUN_RST, rdata: '0};

  core_state_t st_r;
  core_state_t st_nxt;
  qphase_t phase;
  logic cycle_last;
  logic exec_fire;
  logic [DATA_W-1:0] res;
  logic [DATA_W-1:0] bmask;
  logic byte_op;
  logic wr_acc;
  logic wr_file;
  logic redirect;
  logic [PCTR_W-1:0] tgt;
  logic [PCTR_W-1:0] pctr_inc;
  logic [PCTR_W-1:0] call_tgt;
  logic [PCTR_W-1:0] jump_tgt;

  dec_if dif ();

  cycle_phase u_phase (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .run(st_r.run),
    .phase(phase),
    .last(cycle_last)
  );

  word_decoder u_dec (
    .d(dif.dec)
  );

  // A flushed slot executes as a no-op so the fetched word is dropped
  assign dif.word = st_r.flush ? NOP_WORD : st_r.instr;
  assign exec_fire = st_r.run && cycle_last;
  assign pctr_inc = st_r.pctr + PCTR_STEP;
  assign call_tgt = {status_page, 1'b0, dif.k8};
  assign jump_tgt = {status_page, dif.k9};
  assign bmask = BIT_ONE << dif.bitnum;

  // Result and control-flow effects of the word now in execute
  always_comb
  begin
    res = st_r.operand;
    byte_op = 1'b0;
    wr_acc = 1'b0;
    wr_file = 1'b0;
    redirect = 1'b0;
    tgt = pctr_inc;
    case (dif.cls)
      CL_SUB:
      begin
        res = st_r.operand - st_r.acc;
        byte_op = 1'b1;
      end
      CL_IOR_F:
      begin
        res = st_r.operand | st_r.acc;
        byte_op = 1'b1;
      end
      CL_MOV_F:
        byte_op = 1'b1;
      CL_SWAP:
      begin
        res = {st_r.operand[NIB_W-1:0], st_r.operand[DATA_W-1:NIB_W]};
        byte_op = 1'b1;
      end
      CL_CLR_F:
      begin
        res = '0;
        wr_file = 1'b1;
      end
      CL_CLR_W:
      begin
        res = '0;
        wr_acc = 1'b1;
      end
      CL_BCLR:
      begin
        res = st_r.operand & ~bmask;
        wr_file = 1'b1;
      end
      CL_BSET:
      begin
        res = st_r.operand | bmask;
        wr_file = 1'b1;
      end
      // A taken skip costs a second cycle by flushing the next word
      CL_SKIPC:
        redirect = ((st_r.operand & bmask) == '0);
      CL_SKIPS:
        redirect = ((st_r.operand & bmask) != '0);
      CL_CALL:
      begin
        redirect = 1'b1;
        tgt = call_tgt;
      end
      CL_JUMP:
      begin
        redirect = 1'b1;
        tgt = jump_tgt;
      end
      CL_MOVL:
      begin
        res = dif.k8;
        wr_acc = 1'b1;
      end
      CL_IORL:
      begin
        res = st_r.acc | dif.k8;
        wr_acc = 1'b1;
      end
      default:
      begin
        res = st_r.operand;
      end
    endcase
    if (byte_op)
    begin
      wr_acc = !dif.dest;
      wr_file = dif.dest;
    end
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.fwe = 1'b0;
    st_nxt.kick = 1'b0;
    st_nxt.pres_clr = 1'b0;
    st_nxt.rdata = '0;
    if (reg_wr && (reg_addr == REG_CTRL))
      st_nxt.run = reg_wdata[CTRL_RUN_BIT];
    if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL: st_nxt.rdata = REG_W'(st_r.run);
        REG_PCTR: st_nxt.rdata = REG_W'(st_r.pctr);
        REG_ACC: st_nxt.rdata = REG_W'(st_r.acc);
        REG_FLAGS: st_nxt.rdata = REG_W'({st_r.slp, st_r.tmo});
        REG_STACK: st_nxt.rdata = REG_W'(st_r.stack);
        REG_INSTR: st_nxt.rdata = REG_W'(st_r.instr);
        default: st_nxt.rdata = '0;
      endcase
    end
    if (timeout_evt)
      st_nxt.tmo = 1'b0;
    if (sleep_evt)
      st_nxt.slp = 1'b0;
    // File address settles in Q1, data is sampled in Q3
    if (st_r.run && (phase == Q1))
      st_nxt.faddr = dif.faddr;
    if (st_r.run && (phase == Q3))
      st_nxt.operand = file_rdata;
    if (exec_fire)
    begin
      st_nxt.instr = prog_word;
      st_nxt.pctr = tgt;
      st_nxt.flush = redirect;
      if (wr_acc)
        st_nxt.acc = res;
      if (wr_file)
      begin
        st_nxt.fwe = 1'b1;
        st_nxt.fwdata = res;
      end
      if (dif.cls == CL_CALL)
        st_nxt.stack = st_r.pctr;
      if (dif.cls == CL_KICK)
      begin
        // Kick wins over a same-cycle flag clear
        st_nxt.kick = 1'b1;
        st_nxt.pres_clr = pres_guard;
        st_nxt.tmo = 1'b1;
        st_nxt.slp = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_r <= ST_RST;
    else if (ce)
      st_r <= st_nxt;
  end

  assign reg_rdata = st_r.rdata;
  assign prog_addr = st_r.pctr;
  assign file_addr = st_r.faddr;
  assign file_wdata = st_r.fwdata;
  assign file_we = st_r.fwe;
  assign guard_timer_clr = st_r.kick;
  assign prescaler_clr = st_r.pres_clr;
  assign timeout_flag = st_r.tmo;
  assign sleep_flag = st_r.slp;
  assign stack_head = st_r.stack;
  assign accum = st_r.acc;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence seq_fire_call;
    ce && exec_fire && (dif.cls == CL_CALL);
  endsequence

  sequence seq_fire_kick;
    ce && exec_fire && (dif.cls == CL_KICK);
  endsequence

  sequence seq_fire_byte;
    ce && exec_fire && byte_op;
  endsequence

  sequence seq_cycle_start;
    ce && st_r.run && cycle_last;
  endsequence

  AST_FOUR_PHASES: assert property (
    seq_cycle_start ##1 (ce && st_r.run && !cycle_last) [*3] |=> cycle_last)
    else $error("instruction cycle is not four clocks");

  AST_FETCH_WORD: assert property (
    (ce && exec_fire) |=> (st_r.instr == $past(prog_word)))
    else $error("fetched word not latched at cycle end");

  AST_FILE_ADDR: assert property (
    (ce && st_r.run && (phase == Q1)) |=> (file_addr == $past(dif.word[FADDR_W-1:0])))
    else $error("file address not taken from low five bits");

  AST_DEST_ACC: assert property (
    (seq_fire_byte and (!dif.dest)) |=> (!file_we && (accum == $past(res))))
    else $error("byte result with dest 0 not in accumulator");

  AST_DEST_FILE: assert property (
    (seq_fire_byte and dif.dest) |=> (file_we && (file_wdata == $past(res)) && $stable(accum)))
    else $error("byte result with dest 1 not written to file");

  AST_TWO_CYCLE: assert property (
    (ce && exec_fire) |=> (st_r.flush == $past(redirect)))
    else $error("branch or skip did not add a cycle");

  AST_CALL: assert property (
    seq_fire_call |=> (prog_addr == $past(call_tgt)) && (stack_head == $past(st_r.pctr)) && st_r.flush)
    else $error("call target or return address wrong");

  AST_CALL_BIT8: assert property (
    seq_fire_call |=> !prog_addr[K8_W] && (prog_addr[PCTR_W-1:K9_W] == $past(status_page)))
    else $error("call did not clear bit 8 or copy page");

  AST_JUMP: assert property (
    (ce && exec_fire && (dif.cls == CL_JUMP)) |=> (prog_addr == $past(jump_tgt)))
    else $error("long jump target wrong");

  AST_KICK: assert property (
    seq_fire_kick |=> guard_timer_clr && timeout_flag && sleep_flag && (prescaler_clr == $past(pres_guard)))
    else $error("guard timer kick effects missing");

endmodule

// ==== hdl/core_pkg.sv ====
// Shared constants and types of the baseline 12-bit-word core.
// Assumes one clock domain; no file here holds logic.
package core_pkg;

  localparam int WORD_W = 12;
  localparam int PCTR_W = 11;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 5;
  localparam int BIT_W = 3;
  localparam int K8_W = 8;
  localparam int K9_W = 9;
  localparam int PAGE_W = 2;
  localparam int NIB_W = 4;
  localparam int REG_W = 16;
  localparam int RADDR_W = 4;

  // Field positions inside an instruction word
  localparam int F_OP6_LO = 6;
  localparam int F_OP4_LO = 8;
  localparam int F_OP3_LO = 9;
  localparam int F_DEST = 5;
  localparam int F_BIT_LO = 5;

  // Sequencing: four oscillator (clk) periods per instruction cycle
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_PER_CYCLE = 4;

  typedef enum logic [1:0] {
    Q1 = 2'b00,
    Q2 = 2'b01,
    Q3 = 2'b10,
    Q4 = 2'b11
  } qphase_t;

  typedef enum logic [3:0] {
    CL_NOP = 4'b0000,
    CL_SUB = 4'b0001,
    CL_IOR_F = 4'b0010,
    CL_MOV_F = 4'b0011,
    CL_SWAP = 4'b0100,
    CL_CLR_F = 4'b0101,
    CL_CLR_W = 4'b0110,
    CL_BCLR = 4'b0111,
    CL_BSET = 4'b1000,
    CL_SKIPC = 4'b1001,
    CL_SKIPS = 4'b1010,
    CL_CALL = 4'b1011,
    CL_JUMP = 4'b1100,
    CL_MOVL = 4'b1101,
    CL_IORL = 4'b1110,
    CL_KICK = 4'b1111
  } iclass_t;

  // Opcodes
  localparam logic [5:0] OP_CLR = 6'h01;
  localparam logic [5:0] OP_SUB = 6'h02;
  localparam logic [5:0] OP_IOR_F = 6'h04;
  localparam logic [5:0] OP_MOV_F = 6'h08;
  localparam logic [5:0] OP_SWAP = 6'h0e;
  localparam logic [3:0] OP_BCLR = 4'h4;
  localparam logic [3:0] OP_BSET = 4'h5;
  localparam logic [3:0] OP_SKIPC = 4'h6;
  localparam logic [3:0] OP_SKIPS = 4'h7;
  localparam logic [3:0] OP_CALL = 4'h9;
  localparam logic [3:0] OP_MOVL = 4'hc;
  localparam logic [3:0] OP_IORL = 4'hd;
  localparam logic [2:0] OP_JUMP = 3'h5;
  localparam logic [11:0] OP_KICK = 12'h004;
  localparam logic [11:0] NOP_WORD = 12'h000;

  // Register port map (word index on reg_addr)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_PCTR = 4'h1;
  localparam logic [3:0] REG_ACC = 4'h2;
  localparam logic [3:0] REG_FLAGS = 4'h3;
  localparam logic [3:0] REG_STACK = 4'h4;
  localparam logic [3:0] REG_INSTR = 4'h5;
  localparam int CTRL_RUN_BIT = 0;
  localparam int FLAG_TIMEOUT_BIT = 0;
  localparam int FLAG_SLEEP_BIT = 1;

  // Reset values, counter step and bit-mask base
  localparam logic [10:0] PCTR_RST = 11'h000;
  localparam logic [10:0] PCTR_STEP = 11'h001;
  localparam logic [7:0] BIT_ONE = 8'h01;
  localparam logic RUN_RST = 1'b0;
  localparam logic FLAG_RST = 1'b1;

endpackage

// ==== hdl/cycle_phase.sv ====
// Four-phase sequencer that splits each instruction cycle into Q1..Q4.
// Assumes clk is the oscillator; run low parks the sequence in Q1.
`timescale 1ns/100ps
module cycle_phase
  import core_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  output qphase_t phase,
  output logic last
);

  typedef struct packed {
    qphase_t ph;
  } phase_state_t;

  phase_state_t st_r;
  phase_state_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (!run)
    begin
      st_nxt.ph = Q1;
    end
    else
    begin
      case (st_r.ph)
        Q1: st_nxt.ph = Q2;
        Q2: st_nxt.ph = Q3;
        Q3: st_nxt.ph = Q4;
        Q4: st_nxt.ph = Q1;
        default: st_nxt.ph = Q1;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_r <= '{ph: Q1};
    else if (ce)
      st_r <= st_nxt;
  end

  assign phase = st_r.ph;
  assign last = (st_r.ph == Q4);

endmodule

// ==== hdl/dec_if.sv ====
// Carries one instruction word into the decoder and its fields back.
// Assumes a purely combinational decoder on the far side.
`timescale 1ns/100ps
interface dec_if;
  import core_pkg::*;
  logic [WORD_W-1:0] word;
  iclass_t cls;
  logic dest;
  logic [FADDR_W-1:0] faddr;
  logic [BIT_W-1:0] bitnum;
  logic [K8_W-1:0] k8;
  logic [K9_W-1:0] k9;
  modport src (output word, input cls, dest, faddr, bitnum, k8, k9);
  modport dec (input word, output cls, dest, faddr, bitnum, k8, k9);
endinterface

// ==== hdl/word_decoder.sv ====
// Splits a 12-bit instruction word into class and operand fields.
// Combinational; the caller registers whatever it keeps.
`timescale 1ns/100ps
module word_decoder
  import core_pkg::*;
(
  dec_if.dec d
);

  logic [5:0] op6;
  logic [3:0] op4;
  logic [2:0] op3;

  assign op6 = d.word[WORD_W-1:F_OP6_LO];
  assign op4 = d.word[WORD_W-1:F_OP4_LO];
  assign op3 = d.word[WORD_W-1:F_OP3_LO];
  assign d.dest = d.word[F_DEST];
  assign d.faddr = d.word[FADDR_W-1:0];
  assign d.bitnum = d.word[F_BIT_LO+BIT_W-1:F_BIT_LO];
  assign d.k8 = d.word[K8_W-1:0];
  assign d.k9 = d.word[K9_W-1:0];

  always_comb
  begin
    d.cls = CL_NOP;
    if (d.word == OP_KICK)
      d.cls = CL_KICK;
    else if (op6 == OP_CLR)
      // Low five bits are ignored when the target is the accumulator
      d.cls = d.word[F_DEST] ? CL_CLR_F : CL_CLR_W;
    else if (op6 == OP_SUB)
      d.cls = CL_SUB;
    else if (op6 == OP_IOR_F)
      d.cls = CL_IOR_F;
    else if (op6 == OP_MOV_F)
      d.cls = CL_MOV_F;
    else if (op6 == OP_SWAP)
      d.cls = CL_SWAP;
    else if (op4 == OP_BCLR)
      d.cls = CL_BCLR;
    else if (op4 == OP_BSET)
      d.cls = CL_BSET;
    else if (op4 == OP_SKIPC)
      d.cls = CL_SKIPC;
    else if (op4 == OP_SKIPS)
      d.cls = CL_SKIPS;
    else if (op4 == OP_CALL)
      d.cls = CL_CALL;
    else if (op4 == OP_MOVL)
      d.cls = CL_MOVL;
    else if (op4 == OP_IORL)
      d.cls = CL_IORL;
    else if (op3 == OP_JUMP)
      d.cls = CL_JUMP;
  end

endmodule
